// [hw/sfp_flash_seq.sv]
`timescale 1ns/1ns
// Summary of operation
// - chip wipe sets the array to ones, bar blocks skipped in sector scheme; write enable latch needed first
// - write-type commands ending mid-byte are dropped without effect
// - command byte is 8 clocks on one lane or 2 clocks on four
// - self-timed cycle starts at select release; busy flag, then busy and latch clear
// - block-lock scheme: chip wipe runs only when all block protect bits are zero
// - sector scheme: chip wipe skips protected blocks, edge blocks skipped whole
// - page write turns bits to zero with 1 to 256 bytes after write enable
// - more than 256 bytes: only the final 256 are kept
// - low address byte is start offset, bytes wrap within the page
// - page writes to protected blocks are not executed in either scheme
// - quad page write takes address and data on four lanes, needs quad enable
// - no suspend accepted while factory mode is active
// - factory mode clears on reset, op completion and soft reset
// - factory status read is honoured only when idle
// - deep sleep entered after entry delay; all commands ignored there
// - select low for wake width, then recovery delay, returns to standby
// - in OTP mode page write targets the OTP area; locked area allows reads only
// - OTP exit command restores main array access
// - fail flags set on failure or protection, cleared on next success
// - locked OTP area refuses further programming
module sfp_flash_seq
  import sfp_pkg::*;
#(
  parameter int CHIP_WIPE_CYC = ARRAY_ERASE_CYC,
  parameter int PAGE_WRITE_DUR_CYC = PAGE_WRITE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] DATA_LANES_IN,
  output logic [3:0] DATA_LANES_OUT,
  output logic [3:0] DATA_LANES_OE,
  input wire logic FOUR_LANE_COMMAND_FORMAT,
  input wire logic QUAD_LANE_ENABLE,
  input wire logic PROTECTION_SCHEME_SELECT,
  input wire logic [3:0] BLOCK_PROTECT_BITS,
  input wire logic PAGE_BLOCK_LOCKED,
  input wire logic PAGE_SECTOR_LOCKED,
  input wire logic OTP_LOCKDOWN,
  output logic WRITE_IN_PROGRESS,
  output logic WRITE_ENABLE_LATCH,
  output logic ERASE_FAIL,
  output logic PROGRAM_FAIL,
  output logic [7:0] FACTORY_MODE_STATE,
  output logic DEEP_SLEEP,
  output logic OTP_MODE,
  output logic PAGE_WR_EN,
  output logic [7:0] PAGE_WR_IDX,
  output logic [7:0] PAGE_WR_DATA,
  output sfp_op_type ARRAY_OP,
  output logic ARRAY_OP_START,
  output logic SUSPEND_REQ
);
  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic cs_s1_q, cs_s2_q, cs_d1_q, sck_s1_q, sck_s2_q, sck_d1_q;
  logic [3:0] din_s1_q, din_s2_q;

  // two stages before any logic looks at a pin
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {cs_s1_q, cs_s2_q, cs_d1_q} <= 3'h7;
      {sck_s1_q, sck_s2_q, sck_d1_q} <= 3'h0;
      din_s1_q <= 4'h0;
      din_s2_q <= 4'h0;
    end else begin
      {cs_s1_q, cs_s2_q, cs_d1_q} <= {CS_N, cs_s1_q, cs_s2_q};
      {sck_s1_q, sck_s2_q, sck_d1_q} <= {SCLK, sck_s1_q, sck_s2_q};
      din_s1_q <= DATA_LANES_IN;
      din_s2_q <= din_s1_q;
    end
  end

  wire cs_rise = cs_s2_q & ~cs_d1_q;
  wire sck_rise = sck_s2_q & ~sck_d1_q & ~cs_s2_q;
  wire sck_fall = ~sck_s2_q & sck_d1_q & ~cs_s2_q;

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  sfp_state_type state_q;
  logic [2:0] bit_cnt_q, byte_cnt_q;
  logic [7:0] shift_q, opcode_q, data_cnt_q;
  // separate from the count, which wraps to zero after a full page
  logic got_data_q;
  logic [23:0] addr_q;
  logic wel_q, wip_q, efail_q, pfail_q, otp_q, sleep_q, rd_act_q;
  logic [7:0] fm_q, out_q;
  logic [31:0] tmr_q, low_cnt_q;

  // sleep ignores link clock and data, only select is watched for wake; quad lanes for whole command in four-lane format
  wire listen = (state_q != ST_SLEEP) & (state_q != ST_SLEEP_WAIT) & (state_q != ST_WAKE);
  wire quad_now = FOUR_LANE_COMMAND_FORMAT | ((opcode_q == OPC_QUAD_LANE_PAGE_WRITE) & (byte_cnt_q != 3'h0));
  wire [3:0] bit_sum = {1'b0, bit_cnt_q} + (quad_now ? BITS_QUAD : BITS_SERIAL);
  wire [7:0] shifted = quad_now ? {shift_q[3:0], din_s2_q} : {shift_q[6:0], din_s2_q[0]};
  wire step = listen & sck_rise;
  wire byte_done = step & bit_sum[3];
  wire in_data = byte_cnt_q >= BYTES_ADDR_END;
  wire is_pp = (opcode_q == OPC_PAGE_WRITE) | (opcode_q == OPC_QUAD_LANE_PAGE_WRITE);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      data_cnt_q <= 8'h00;
      got_data_q <= 1'b0;
    end else if (cs_s2_q) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      data_cnt_q <= 8'h00;
      got_data_q <= 1'b0;
    end else if (step) begin
      bit_cnt_q <= bit_sum[2:0];
      shift_q <= shifted;
      if (byte_done) begin
        if (byte_cnt_q == 3'h0) opcode_q <= shifted;
        else if (!in_data) addr_q <= {addr_q[15:0], shifted};
        else begin
          data_cnt_q <= data_cnt_q + 8'h01;
          got_data_q <= 1'b1;
        end
        if (!in_data) byte_cnt_q <= byte_cnt_q + 3'h1;
      end
    end
  end

  // page buffer strobe: index wraps in the page, later bytes overwrite earlier ones
  logic pwe_q;
  logic [7:0] pidx_q, pdat_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwe_q <= 1'b0;
      pidx_q <= 8'h00;
      pdat_q <= 8'h00;
    end else begin
      pwe_q <= byte_done & in_data & is_pp & (state_q == ST_IDLE);
      pidx_q <= addr_q[7:0] + data_cnt_q;
      pdat_q <= shifted;
    end
  end

  // ---------------------------------------------------------------
  // command decode at select release; status read at end of its opcode byte
  // ---------------------------------------------------------------
  wire boundary = bit_cnt_q == 3'h0;
  wire exec = cs_rise & boundary & (state_q == ST_IDLE);
  wire only_cmd = byte_cnt_q == BYTES_CMD;
  wire ce_req = exec & only_cmd & (opcode_q == OPC_CHIP_WIPE) & wel_q & ~otp_q;
  wire ce_block = ~PROTECTION_SCHEME_SELECT & (BLOCK_PROTECT_BITS != 4'h0);
  wire pp_cmd = (opcode_q == OPC_PAGE_WRITE) | ((opcode_q == OPC_QUAD_LANE_PAGE_WRITE) & QUAD_LANE_ENABLE);
  wire pp_req = exec & pp_cmd & in_data & got_data_q & wel_q;
  wire pp_block = otp_q ? OTP_LOCKDOWN : (PROTECTION_SCHEME_SELECT ? PAGE_SECTOR_LOCKED : PAGE_BLOCK_LOCKED);
  wire ce_go = ce_req & ~ce_block;
  wire pp_go = pp_req & ~pp_block;
  wire dp_go = exec & only_cmd & (opcode_q == OPC_DEEP_SLEEP_CMD);
  wire plain = exec & only_cmd;
  wire susp_ok = cs_rise & boundary & only_cmd & (opcode_q == OPC_SUSPEND) & (state_q == ST_BUSY)
    & (fm_q == FACTORY_OFF);
  wire op_done = (state_q == ST_BUSY) & (tmr_q == 32'h0);
  wire rd_go = byte_done & (byte_cnt_q == 3'h0) & (shifted == OPC_FACTORY_STATUS_READ) & (state_q == ST_IDLE);

  // ---------------------------------------------------------------
  // sequencer: busy, sleep entry, sleep, wake
  // ---------------------------------------------------------------
  sfp_op_type op_q;
  logic start_q, susp_q;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      tmr_q <= 32'h0;
      op_q <= '0;
      start_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      start_q <= ce_go | pp_go;
      susp_q <= susp_ok;
      if (tmr_q != 32'h0) tmr_q <= tmr_q - 32'h1;
      case (state_q)
        ST_IDLE: begin
          if (ce_go | pp_go) begin
            state_q <= ST_BUSY;
            op_q.kind <= ce_go ? OPK_CHIP_WIPE : OPK_PAGE_WRITE;
            op_q.addr <= addr_q;
            op_q.otp <= otp_q;
            op_q.skip_locked <= ce_go & PROTECTION_SCHEME_SELECT;
            op_q.fast <= fm_q == FACTORY_ON;
            // factory mode shortens the cycle
            if (ce_go) tmr_q <= (fm_q == FACTORY_ON) ? 32'(CHIP_WIPE_CYC / 2) : 32'(CHIP_WIPE_CYC);
            else tmr_q <= (fm_q == FACTORY_ON) ? 32'(PAGE_WRITE_DUR_CYC / 2) : 32'(PAGE_WRITE_DUR_CYC);
          end else if (dp_go) begin
            state_q <= ST_SLEEP_WAIT;
            tmr_q <= 32'(SLEEP_ENTRY_CYC);
          end
        end
        ST_BUSY: if (op_done) state_q <= ST_IDLE;
        ST_SLEEP_WAIT: if (tmr_q == 32'h0) state_q <= ST_SLEEP;
        ST_SLEEP: begin
          // a short glitch on select does not wake the part
          if (cs_rise & (low_cnt_q >= 32'(WAKE_PULSE_CYC))) begin
            state_q <= ST_WAKE;
            tmr_q <= 32'(WAKE_RECOVERY_CYC);
          end
        end
        ST_WAKE: if (tmr_q == 32'h0) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // select low time, measured for the wake pulse
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) low_cnt_q <= 32'h0;
    else if (cs_s2_q) low_cnt_q <= 32'h0;
    else if (low_cnt_q != 32'hFFFFFFFF) low_cnt_q <= low_cnt_q + 32'h1;
  end

  // ---------------------------------------------------------------
  // status flags and modes
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      efail_q <= 1'b0;
      pfail_q <= 1'b0;
      fm_q <= FACTORY_OFF;
      otp_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      wip_q <= (ce_go | pp_go) | (wip_q & ~op_done);
      sleep_q <= (state_q == ST_SLEEP_WAIT) & (tmr_q == 32'h0) | (sleep_q & ~(state_q == ST_WAKE & tmr_q == 32'h0));
      if (op_done | (plain & (opcode_q == OPC_SOFT_RESET))) wel_q <= 1'b0;
      else if (plain & (opcode_q == OPC_WRITE_ENABLE_CMD)) wel_q <= 1'b1;
      if (ce_req & ce_block) efail_q <= 1'b1;
      else if (op_done & (op_q.kind == OPK_CHIP_WIPE)) efail_q <= 1'b0;
      if (pp_req & pp_block) pfail_q <= 1'b1;
      else if (op_done & (op_q.kind == OPK_PAGE_WRITE)) pfail_q <= 1'b0;
      if (op_done | (plain & (opcode_q == OPC_SOFT_RESET))) fm_q <= FACTORY_OFF;
      else if (plain & (opcode_q == OPC_FACTORY_ACCEL_ENABLE) & wel_q) fm_q <= FACTORY_ON;
      if (plain & ((opcode_q == OPC_OTP_AREA_EXIT) | (opcode_q == OPC_SOFT_RESET))) otp_q <= 1'b0;
      else if (plain & (opcode_q == OPC_OTP_AREA_ENTER)) otp_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // factory status readback, driven on falling link clock
  // ---------------------------------------------------------------
  logic [3:0] lout_q, loe_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_act_q <= 1'b0;
      out_q <= 8'h00;
      lout_q <= 4'h0;
      loe_q <= 4'h0;
    end else if (cs_s2_q) begin
      rd_act_q <= 1'b0;
      loe_q <= 4'h0;
    end else if (rd_go) begin
      rd_act_q <= 1'b1;
      out_q <= fm_q;
    end else if (rd_act_q & sck_fall) begin
      // rotate so the byte repeats while select stays low
      lout_q <= FOUR_LANE_COMMAND_FORMAT ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
      loe_q <= FOUR_LANE_COMMAND_FORMAT ? OE_QUAD : OE_SERIAL;
      out_q <= FOUR_LANE_COMMAND_FORMAT ? {out_q[3:0], out_q[7:4]} : {out_q[6:0], out_q[7]};
    end
  end

  assign DATA_LANES_OUT = lout_q;
  assign DATA_LANES_OE = loe_q;
  assign WRITE_IN_PROGRESS = wip_q;
  assign WRITE_ENABLE_LATCH = wel_q;
  assign ERASE_FAIL = efail_q;
  assign PROGRAM_FAIL = pfail_q;
  assign FACTORY_MODE_STATE = fm_q;
  assign DEEP_SLEEP = sleep_q;
  assign OTP_MODE = otp_q;
  assign PAGE_WR_EN = pwe_q;
  assign PAGE_WR_IDX = pidx_q;
  assign PAGE_WR_DATA = pdat_q;
  assign ARRAY_OP = op_q;
  assign ARRAY_OP_START = start_q;
  assign SUSPEND_REQ = susp_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  sequence seq_rd_cmd;
    rd_go;
  endsequence
  sequence seq_finish;
    wip_q ##1 !wip_q;
  endsequence

  AST_START_BUSY: assert property (start_q |-> wip_q) else $error("cycle started without busy");
  AST_FINISH_CLEAR: assert property (seq_finish |-> !wel_q && fm_q == FACTORY_OFF)
    else $error("busy fell but latch or factory mode stayed");
  AST_BP_BLOCK: assert property (start_q && op_q.kind == OPK_CHIP_WIPE
    |-> $past(PROTECTION_SCHEME_SELECT) || $past(BLOCK_PROTECT_BITS) == 4'h0) else $error("wipe ran under protect");
  AST_SKIP_MODE: assert property (start_q && op_q.kind == OPK_CHIP_WIPE |-> op_q.skip_locked == $past(PROTECTION_SCHEME_SELECT))
    else $error("skip flag does not follow scheme");
  AST_MIDBYTE: assert property (cs_rise && !boundary |=> !start_q && $stable(wel_q)) else $error("mid-byte command acted");
  AST_WRAP: assert property (pwe_q |-> pidx_q == $past(addr_q[7:0]) + $past(data_cnt_q))
    else $error("page index does not wrap from start offset");
  AST_SLEEP_DEAF: assert property (state_q == ST_SLEEP |=> !start_q && !rd_act_q) else $error("command taken in sleep");
  AST_RD_LOAD: assert property (seq_rd_cmd |=> rd_act_q && out_q == $past(fm_q)) else $error("status read not loaded");
  AST_RD_BUSY: assert property (wip_q |-> !rd_go) else $error("status read honoured while busy");
  AST_NO_SUSP: assert property (fm_q == FACTORY_ON |=> !susp_q) else $error("suspend in factory mode");
endmodule : sfp_flash_seq

// [hw/sfp_pkg.sv]
package sfp_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_CHIP_WIPE = 8'hC7;
  localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OPC_QUAD_LANE_PAGE_WRITE = 8'h38;
  localparam logic [7:0] OPC_FACTORY_ACCEL_ENABLE = 8'h41;
  localparam logic [7:0] OPC_FACTORY_STATUS_READ = 8'h44;
  localparam logic [7:0] OPC_DEEP_SLEEP_CMD = 8'hB9;
  localparam logic [7:0] OPC_OTP_AREA_ENTER = 8'hB1;
  localparam logic [7:0] OPC_OTP_AREA_EXIT = 8'hC1;
  localparam logic [7:0] OPC_SUSPEND = 8'hB0;
  localparam logic [7:0] OPC_SOFT_RESET = 8'h99;
  // ---------------------------------------------------------------
  // frame layout and register values
  // ---------------------------------------------------------------
  localparam logic [2:0] BYTES_CMD = 3'h1;
  localparam logic [2:0] BYTES_ADDR_END = 3'h4;
  localparam logic [3:0] BITS_SERIAL = 4'h1;
  localparam logic [3:0] BITS_QUAD = 4'h4;
  localparam logic [7:0] FACTORY_ON = 8'hFF;
  localparam logic [7:0] FACTORY_OFF = 8'h00;
  localparam logic [3:0] OE_SERIAL = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hF;
  localparam logic [1:0] OPK_NONE = 2'h0;
  localparam logic [1:0] OPK_CHIP_WIPE = 2'h1;
  localparam logic [1:0] OPK_PAGE_WRITE = 2'h2;
  // ---------------------------------------------------------------
  // timing, times in their own unit, counts derived
  // ---------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 10;
  localparam int SLEEP_ENTRY_DELAY_NS = 10000;
  localparam int WAKE_PULSE_WIDTH_NS = 30;
  localparam int WAKE_RECOVERY_DELAY_NS = 30000;
  localparam int ARRAY_ERASE_TIME_US = 50000;
  localparam int PAGE_WRITE_TIME_US = 500;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_WIDTH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int WAKE_RECOVERY_CYC = (WAKE_RECOVERY_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * 1000 / SYS_PERIOD_NS;
  localparam int PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * 1000 / SYS_PERIOD_NS;

  typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_SLEEP_WAIT, ST_SLEEP, ST_WAKE} sfp_state_type;

  // operation handed to the array engine
  typedef struct packed {
    logic [1:0] kind;
    logic [23:0] addr;
    logic otp;
    logic skip_locked;
    logic fast;
  } sfp_op_type;
endpackage : sfp_pkg

// [verification/sfp_host_model.sv]
`timescale 1ns/1ns
module sfp_host_model (
  input wire logic SYS_CLK,
  output logic CS_N,
  output logic SCLK,
  output logic [3:0] DATA_LANES_IN,
  input wire logic [3:0] DATA_LANES_OUT
);
  logic [7:0] rd;

  // ------------------------------------------------------------
  // frame driver
  // ------------------------------------------------------------
  // idle: deselected, link clock parked low between frames
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    DATA_LANES_IN = 4'hA;
    rd = 8'h00;
  end

  task automatic start();
    @(posedge SYS_CLK);
    CS_N <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
  endtask : start

  // n units of b, msb first; a quad unit is one nibble
  task automatic put(input logic [7:0] b, input logic quad, input int n);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < n; i++) begin
      // data moves with the falling link clock, 16 cycles a unit
      // upper lanes carry junk in serial so a stray look is caught
      DATA_LANES_IN <= quad ? s[7:4] : {~s[6:4], s[7]};
      s = quad ? {s[3:0], 4'h0} : {s[6:0], 1'b0};
      repeat (8) @(posedge SYS_CLK);
      rd = quad ? {rd[3:0], DATA_LANES_OUT} : {rd[6:0], DATA_LANES_OUT[1]};
      SCLK <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      SCLK <= 1'b0;
    end
  endtask : put

  // release on a unit edge; released lanes flip so stale bits never pass
  task automatic stop();
    repeat (4) @(posedge SYS_CLK);
    CS_N <= 1'b1;
    DATA_LANES_IN <= ~DATA_LANES_IN;
    repeat (8) @(posedge SYS_CLK);
  endtask : stop
endmodule : sfp_host_model

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import sfp_pkg::*;
  logic SYS_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic fq = 1'b0, qe = 1'b0, psel = 1'b0, blk_lk = 1'b0, sec_lk = 1'b0, otp_lk = 1'b0;
  logic cs_n, sclk, write_in_progress, write_enable_latch, efail, pfail, sleep, otp, wr_en, st, susp_req;
  logic susp = 1'b0, oe_seen = 1'b0;
  logic [3:0] bp = 4'h0;
  logic [3:0] host_lanes, lanes, lanes_out, lanes_oe;
  logic [7:0] fm, wr_idx, wr_dat, last_idx, last_dat;
  sfp_op_type op;
  int fails = 0, checks = 0, starts = 0, wr_n = 0, wip_n = 0;

  always #5 SYS_CLK = ~SYS_CLK;
  // shared lanes: the device wins wherever it enables
  assign lanes = (lanes_oe & lanes_out) | (~lanes_oe & host_lanes);

  sfp_flash_seq #(.CHIP_WIPE_CYC(1000), .PAGE_WRITE_DUR_CYC(50)) dut_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .CS_N(cs_n), .SCLK(sclk), .DATA_LANES_IN(lanes), .DATA_LANES_OUT(lanes_out), .DATA_LANES_OE(lanes_oe),
    .FOUR_LANE_COMMAND_FORMAT(fq), .QUAD_LANE_ENABLE(qe), .PROTECTION_SCHEME_SELECT(psel),
    .BLOCK_PROTECT_BITS(bp), .PAGE_BLOCK_LOCKED(blk_lk), .PAGE_SECTOR_LOCKED(sec_lk), .OTP_LOCKDOWN(otp_lk),
    .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .ERASE_FAIL(efail), .PROGRAM_FAIL(pfail),
    .FACTORY_MODE_STATE(fm), .DEEP_SLEEP(sleep), .OTP_MODE(otp), .PAGE_WR_EN(wr_en), .PAGE_WR_IDX(wr_idx),
    .PAGE_WR_DATA(wr_dat), .ARRAY_OP(op), .ARRAY_OP_START(st), .SUSPEND_REQ(susp_req));

  sfp_host_model host_u (.SYS_CLK(SYS_CLK), .CS_N(cs_n), .SCLK(sclk), .DATA_LANES_IN(host_lanes),
    .DATA_LANES_OUT(lanes_out));

  // ------------------------------------------------------------
  // tallies of one-cycle pulses, which tasks would miss
  // ------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (st === 1'b1) starts <= starts + 1;
    if (write_in_progress === 1'b1) wip_n <= wip_n + 1;
    if (susp_req === 1'b1) susp <= 1'b1;
    if (lanes_oe !== 4'h0) oe_seen <= 1'b1;
    if (wr_en === 1'b1) begin
      wr_n <= wr_n + 1;
      last_idx <= wr_idx;
      last_dat <= wr_dat;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // frame helpers
  // ------------------------------------------------------------
  task automatic do_reset();
    @(posedge SYS_CLK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
  endtask : do_reset

  task automatic cmd(input logic [7:0] c);
    host_u.start();
    host_u.put(c, fq, fq ? 2 : 8);
    host_u.stop();
  endtask : cmd

  // opcode, three address bytes, n data bytes counting up from d
  task automatic pw(input logic [7:0] c, input logic [23:0] a, input int n, input logic [7:0] d);
    logic q;
    q = fq | (c == OPC_QUAD_LANE_PAGE_WRITE);
    host_u.start();
    host_u.put(c, fq, fq ? 2 : 8);
    for (int i = 0; i < 3; i++) host_u.put(a[23-8*i -: 8], q, q ? 2 : 8);
    for (int i = 0; i < n; i++) host_u.put(d + i[7:0], q, q ? 2 : 8);
    host_u.stop();
  endtask : pw

  task automatic rdfm(output logic [7:0] v);
    host_u.start();
    host_u.put(OPC_FACTORY_STATUS_READ, fq, fq ? 2 : 8);
    host_u.put(8'h00, fq, fq ? 2 : 8);
    host_u.stop();
    v = host_u.rd;
  endtask : rdfm

  // bounded wait for the self-timed cycle to end
  task automatic idle();
    for (int i = 0; i < 1200 && write_in_progress !== 1'b0; i++) @(posedge SYS_CLK);
    chk("wip_done", 0, write_in_progress);
    repeat (2) @(posedge SYS_CLK);
  endtask : idle

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_chip();
    int s0;
    logic [7:0] v;
    s0 = starts;
    chk("reset_flags", 0, {write_in_progress, write_enable_latch, efail, pfail, sleep, otp, lanes_oe, fm});
    cmd(OPC_CHIP_WIPE);
    chk("wipe_no_latch", s0, starts);
    cmd(OPC_WRITE_ENABLE_CMD);
    chk("latch_set", 1, write_enable_latch);
    host_u.start();
    host_u.put(OPC_CHIP_WIPE, 1'b0, 7);
    host_u.stop();
    chk("wipe_mid_byte", s0, starts);
    wip_n = 0;
    cmd(OPC_CHIP_WIPE);
    chk("wipe_kind", OPK_CHIP_WIPE, op.kind);
    oe_seen = 1'b0;
    susp = 1'b0;
    rdfm(v);
    chk("read_while_busy", 0, oe_seen);
    cmd(OPC_SUSPEND);
    chk("suspend_normal", 1, susp);
    idle();
    // busy also covers the cycle in which the timer reads zero
    chk("wipe_time", 1001, wip_n);
    chk("wipe_latch_clear", 0, write_enable_latch);
  endtask : t_chip

  task automatic t_protect();
    int s0;
    cmd(OPC_WRITE_ENABLE_CMD);
    bp <= 4'h2;
    s0 = starts;
    cmd(OPC_CHIP_WIPE);
    chk("wipe_blocked", s0, starts);
    chk("erase_fail_set", 1, efail);
    psel <= 1'b1;
    bp <= 4'hF;
    fq <= 1'b1;
    cmd(OPC_CHIP_WIPE);
    chk("wipe_quad_cmd", s0 + 1, starts);
    chk("wipe_skip_locked", 1, op.skip_locked);
    idle();
    chk("erase_fail_clear", 0, efail);
    fq <= 1'b0;
    bp <= 4'h0;
  endtask : t_protect

  task automatic t_page();
    int s0, n0;
    sec_lk <= 1'b1;
    cmd(OPC_WRITE_ENABLE_CMD);
    s0 = starts;
    pw(OPC_PAGE_WRITE, 24'h0102FE, 1, 8'h11);
    chk("write_sector_locked", s0, starts);
    chk("program_fail_set", 1, pfail);
    psel <= 1'b0;
    sec_lk <= 1'b0;
    blk_lk <= 1'b1;
    pw(OPC_PAGE_WRITE, 24'h0102FE, 1, 8'h11);
    chk("write_block_locked", s0, starts);
    blk_lk <= 1'b0;
    pw(OPC_PAGE_WRITE, 24'h0102FE, 0, 8'h11);
    chk("write_no_data", s0, starts);
    wip_n = 0;
    n0 = wr_n;
    pw(OPC_PAGE_WRITE, 24'h0102FE, 3, 8'hA5);
    chk("write_addr", 24'h0102FE, op.addr);
    chk("write_count", n0 + 3, wr_n);
    chk("write_wrap_idx", 8'h00, last_idx);
    chk("write_last_data", 8'hA7, last_dat);
    idle();
    chk("write_time", 51, wip_n);
    chk("program_fail_clear", 0, pfail);
  endtask : t_page

  task automatic t_quad();
    int s0;
    cmd(OPC_WRITE_ENABLE_CMD);
    s0 = starts;
    pw(OPC_QUAD_LANE_PAGE_WRITE, 24'h000010, 1, 8'h00);
    chk("quad_no_enable", s0, starts);
    qe <= 1'b1;
    pw(OPC_QUAD_LANE_PAGE_WRITE, 24'h000010, 258, 8'h00);
    chk("quad_kind", OPK_PAGE_WRITE, op.kind);
    chk("quad_last_idx", 8'h11, last_idx);
    chk("quad_last_data", 8'h01, last_dat);
    idle();
    // exactly one full page must still be accepted
    cmd(OPC_WRITE_ENABLE_CMD);
    s0 = starts;
    pw(OPC_QUAD_LANE_PAGE_WRITE, 24'h000000, 256, 8'h00);
    chk("quad_full_page", s0 + 1, starts);
    chk("quad_full_idx", 8'hFF, last_idx);
    idle();
    qe <= 1'b0;
  endtask : t_quad

  task automatic t_factory();
    logic [7:0] v;
    cmd(OPC_WRITE_ENABLE_CMD);
    cmd(OPC_FACTORY_ACCEL_ENABLE);
    rdfm(v);
    chk("factory_read_on", FACTORY_ON, v);
    wip_n = 0;
    susp = 1'b0;
    cmd(OPC_CHIP_WIPE);
    chk("factory_fast", 1, op.fast);
    cmd(OPC_SUSPEND);
    chk("suspend_refused", 0, susp);
    idle();
    chk("factory_time", 501, wip_n);
    chk("factory_done_clear", FACTORY_OFF, fm);
    rdfm(v);
    chk("factory_read_off", FACTORY_OFF, v);
    cmd(OPC_WRITE_ENABLE_CMD);
    cmd(OPC_FACTORY_ACCEL_ENABLE);
    do_reset();
    chk("factory_reset_clear", FACTORY_OFF, fm);
  endtask : t_factory

  task automatic t_sleep();
    cmd(OPC_DEEP_SLEEP_CMD);
    chk("sleep_delay", 0, sleep);
    for (int i = 0; i < 1100 && sleep !== 1'b1; i++) @(posedge SYS_CLK);
    chk("sleep_entered", 1, sleep);
    repeat (20) @(posedge SYS_CLK);
    cmd(OPC_WRITE_ENABLE_CMD);
    chk("wake_recovering", 1, sleep);
    for (int i = 0; i < 3100 && sleep !== 1'b0; i++) @(posedge SYS_CLK);
    chk("wake_done", 0, sleep);
    chk("sleep_ignored", 0, write_enable_latch);
  endtask : t_sleep

  task automatic t_otp();
    int s0;
    cmd(OPC_OTP_AREA_ENTER);
    chk("otp_on", 1, otp);
    cmd(OPC_WRITE_ENABLE_CMD);
    s0 = starts;
    cmd(OPC_CHIP_WIPE);
    chk("otp_no_wipe", s0, starts);
    pw(OPC_PAGE_WRITE, 24'h000020, 1, 8'h5A);
    chk("otp_target", 1, op.otp);
    idle();
    otp_lk <= 1'b1;
    cmd(OPC_WRITE_ENABLE_CMD);
    s0 = starts;
    pw(OPC_PAGE_WRITE, 24'h000020, 1, 8'h5A);
    chk("otp_locked", s0, starts);
    otp_lk <= 1'b0;
    cmd(OPC_OTP_AREA_EXIT);
    chk("otp_off", 0, otp);
  endtask : t_otp

  initial begin
    do_reset();
    t_chip();
    t_protect();
    t_page();
    t_quad();
    t_factory();
    t_sleep();
    t_otp();
    summarize();
  end

  // watchdog: the sequence needs about half of this
  initial begin
    #700000;
    fails++;
    summarize();
  end
endmodule : testbench
